// file: inc/pqdc_pkg.sv
// pqdc_pkg: constants and carriers for the prefetch queue drop control
// assumes one core clock; all users write pqdc_pkg::name
package pqdc_pkg;
  localparam int PQDC_DEPTH = 8;
  localparam int PQDC_IDX_W = 3;
  localparam int PQDC_CNT_W = 4;
  localparam int PQDC_LINE_W = 26;
  localparam int PQDC_AGE_W = 6;
  // configurable oversubscription thresholds
  localparam logic [PQDC_AGE_W-1:0] PQDC_AGE_MAX = 6'h20; // RL18
  localparam logic [PQDC_CNT_W-1:0] PQDC_SW_MAX = 4'h6; // RL18
  localparam logic [PQDC_CNT_W-1:0] PQDC_FULL = 4'h8;
  localparam logic [PQDC_CNT_W-1:0] PQDC_CNT_RST = 4'h0;
  localparam logic [PQDC_IDX_W-1:0] PQDC_IDX_RST = 3'h0;
  localparam logic [PQDC_AGE_W-1:0] PQDC_AGE_RST = 6'h00;

  typedef enum logic [1:0] {
    PQDC_HINT_NORMAL,
    PQDC_HINT_TLB_L2,
    PQDC_HINT_ANY
  } pqdc_hint_t;

  typedef enum logic [3:0] {
    PQDC_WHY_NONE,
    PQDC_WHY_L1_HIT,
    PQDC_WHY_FILL_BUSY,
    PQDC_WHY_TLB1_MISS,
    PQDC_WHY_XLAT_MISS,
    PQDC_WHY_ADDR_FAULT,
    PQDC_WHY_L2_HIT,
    PQDC_WHY_L2_MISS,
    PQDC_WHY_L2_SEC
  } pqdc_why_t;

  typedef struct packed {
    logic [PQDC_LINE_W-1:0] line;
    logic sw;
    pqdc_hint_t hint;
    logic no_alloc;
  } pqdc_entry_t;

  typedef struct packed {
    pqdc_hint_t hint;
    logic no_alloc;
    logic virt;
    logic faulting;
    logic addr_fault;
    logic l1_hit;
    logic fab_full;
    logic fab_same;
    logic tlb1_miss;
    logic xlat_miss;
    logic l2_hit;
    logic l2_miss;
    logic l2_sec;
    logic fill_cancel;
  } pqdc_res_t;

  localparam pqdc_entry_t PQDC_ENTRY_RST = '0;
endpackage

// file: core/pqdc_head_age.sv
// pqdc_head_age: saturating age counter of the queue head entry
// assumes clear is high whenever the head leaves or the queue is empty
`timescale 1ns/1ps
module pqdc_head_age (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // control
  input wire logic clear,
  // age
  output logic [pqdc_pkg::PQDC_AGE_W-1:0] age_r
);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      age_r <= pqdc_pkg::PQDC_AGE_RST;
    end else if (clear) begin
      age_r <= pqdc_pkg::PQDC_AGE_RST;
    end else if (age_r != pqdc_pkg::PQDC_AGE_MAX) begin
      age_r <= age_r + pqdc_pkg::PQDC_AGE_W'(1); // RL2
    end
  end

  property p_age_sat;
    @(posedge ref_clk) disable iff (sys_rst) age_r <= pqdc_pkg::PQDC_AGE_MAX;
  endproperty
  a_age_sat: assert property (p_age_sat) else $error("head age past limit"); // RL2
endmodule

// file: core/pqdc_drop_filter.sv
// pqdc_drop_filter: per-hint drop decision on the lookups of one prefetch
// assumes res carries the hints of the prefetch together with its lookups
`timescale 1ns/1ps
module pqdc_drop_filter (
  // lookup results
  input wire pqdc_pkg::pqdc_res_t res,
  // decision
  output logic drop,
  output pqdc_pkg::pqdc_why_t why,
  output logic l1_fill
);
  logic wants_l1;
  logic only_l1;

  assign wants_l1 = res.virt && !res.no_alloc;
  assign only_l1 = (res.hint != pqdc_pkg::PQDC_HINT_NORMAL) && !res.no_alloc;

  always_comb begin
    why = pqdc_pkg::PQDC_WHY_NONE;
    if (res.virt && !res.faulting && res.addr_fault) begin
      why = pqdc_pkg::PQDC_WHY_ADDR_FAULT; // RL11
    end else if (res.hint != pqdc_pkg::PQDC_HINT_NORMAL && res.xlat_miss) begin
      why = pqdc_pkg::PQDC_WHY_XLAT_MISS; // RL10
    end else if (res.hint == pqdc_pkg::PQDC_HINT_ANY && res.tlb1_miss) begin
      why = pqdc_pkg::PQDC_WHY_TLB1_MISS; // RL9
    end else if (res.l1_hit) begin
      why = pqdc_pkg::PQDC_WHY_L1_HIT; // RL7
    end else if (only_l1 && (res.fab_full || res.fab_same)) begin
      why = pqdc_pkg::PQDC_WHY_FILL_BUSY; // RL8
    end else if (res.l2_sec) begin
      why = pqdc_pkg::PQDC_WHY_L2_SEC; // RL14
    end else if (!wants_l1 && res.l2_hit) begin
      why = pqdc_pkg::PQDC_WHY_L2_HIT; // RL12
    end else if (res.hint != pqdc_pkg::PQDC_HINT_NORMAL && res.l2_miss) begin
      why = pqdc_pkg::PQDC_WHY_L2_MISS; // RL13
    end
  end

  assign drop = (why != pqdc_pkg::PQDC_WHY_NONE);
  // a cancelled first-level fill leaves the outer fill in place
  assign l1_fill = wants_l1 && !drop && !res.fill_cancel && !res.fab_full
    && !res.fab_same && !res.tlb1_miss; // RL15
endmodule

// file: core/pqdc_top.sv
// pqdc_top: prefetch queue with oversubscription and drop control
// assumes the pipeline reports lookups of issued prefetches on res_*
// and presents ordering-queue retries on the insert port
`timescale 1ns/1ps
// How it works
// (RL1) inserting into a full queue discards the oldest entry
// (RL2) head age, occupancy and software prefetch count are always tracked
// (RL3) old head or many software prefetches: drop a hardware head
// (RL4) same condition, ready software head: block issue one cycle
// (RL5) software at risk and head waiting: replay pipeline until it clears
// (RL6) any-miss hinted line prefetch counts as hardware for oversubscription
// (RL7) drop prefetches that hit the first-level cache
// (RL8) fill-only prefetch dropped when fill buffer full or line already filling
// (RL9) any-miss hinted prefetch dropped on first-level translation miss
// (RL10) non-normal hinted prefetch dropped on translation buffer miss
// (RL11) non-faulting virtual prefetch with address fault is silently dropped
// (RL12) prefetch without first-level fill dropped on mid-level hit
// (RL13) hinted prefetch dropped on mid-level miss
// (RL14) mid-level secondary miss prefetch is dropped
// (RL15) fill cancel removes first-level part, outer fill may proceed
// (RL16) stale hardware prefetches go before software ones
// (RL17) ordering-queue rejects re-enter behind all queued entries
// (RL18) age and software thresholds are configurable constants
module pqdc_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // insert
  input wire logic ins_valid,
  input wire pqdc_pkg::pqdc_entry_t ins_entry,
  // issue
  output logic iss_valid_r,
  output pqdc_pkg::pqdc_entry_t iss_entry_r,
  input wire logic iss_take,
  input wire logic hd_wait,
  output logic blk_issue_r,
  output logic replay_r,
  // drop events
  output logic ovf_drop_r,
  output logic stale_drop_r,
  // tracked state
  output logic [pqdc_pkg::PQDC_CNT_W-1:0] occupancy_r,
  output logic [pqdc_pkg::PQDC_CNT_W-1:0] sw_cnt_r,
  output logic [pqdc_pkg::PQDC_AGE_W-1:0] head_age_r,
  // lookup results
  input wire logic res_valid,
  input wire pqdc_pkg::pqdc_res_t res,
  output logic res_drop_r,
  output pqdc_pkg::pqdc_why_t res_why_r,
  output logic l1_fill_r,
  output logic l2_fill_r
);
  ////////////////////////////////////////////////////////////////////////
  pqdc_pkg::pqdc_entry_t mem_r [pqdc_pkg::PQDC_DEPTH];
  logic [pqdc_pkg::PQDC_IDX_W-1:0] head_r;
  logic [pqdc_pkg::PQDC_IDX_W-1:0] tail_r;
  logic [pqdc_pkg::PQDC_IDX_W-1:0] head_nxt;
  logic [pqdc_pkg::PQDC_CNT_W-1:0] cnt_nxt;
  logic [pqdc_pkg::PQDC_CNT_W-1:0] sw_nxt;
  logic full;
  logic over;
  logic hd_sw;
  logic ins_sw;
  logic hw_drop;
  logic pop_norm;
  logic ovf;
  logic pop;
  logic flt_drop;
  logic flt_l1;
  pqdc_pkg::pqdc_why_t flt_why;

  ////////////////////////////////////////////////////////////////////////
  // oversubscription decision on the registered head
  assign full = (occupancy_r == pqdc_pkg::PQDC_FULL);
  assign over = (head_age_r >= pqdc_pkg::PQDC_AGE_MAX)
    || (sw_cnt_r >= pqdc_pkg::PQDC_SW_MAX); // RL2
  // any-miss hinted software prefetches are treated as hardware
  assign hd_sw = iss_entry_r.sw
    && (iss_entry_r.hint != pqdc_pkg::PQDC_HINT_ANY); // RL6
  assign ins_sw = ins_entry.sw
    && (ins_entry.hint != pqdc_pkg::PQDC_HINT_ANY); // RL6
  assign hw_drop = iss_valid_r && over && !hd_sw; // RL3 RL16
  assign pop_norm = hw_drop || (iss_valid_r && iss_take);
  assign ovf = ins_valid && full && !pop_norm; // RL1
  assign pop = pop_norm || ovf;
  assign head_nxt = head_r + pqdc_pkg::PQDC_IDX_W'(pop);
  assign cnt_nxt = occupancy_r + pqdc_pkg::PQDC_CNT_W'(ins_valid)
    - pqdc_pkg::PQDC_CNT_W'(pop);
  assign sw_nxt = sw_cnt_r + pqdc_pkg::PQDC_CNT_W'(ins_valid && ins_sw)
    - pqdc_pkg::PQDC_CNT_W'(pop && hd_sw);

  ////////////////////////////////////////////////////////////////////////
  // storage; a retry is written at the tail like any other insert
  for (genvar i = 0; i < pqdc_pkg::PQDC_DEPTH; i++) begin : g_ent
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem_r[i] <= pqdc_pkg::PQDC_ENTRY_RST;
      end else if (ins_valid && tail_r == pqdc_pkg::PQDC_IDX_W'(i)) begin
        mem_r[i] <= ins_entry; // RL17
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      head_r <= pqdc_pkg::PQDC_IDX_RST;
      tail_r <= pqdc_pkg::PQDC_IDX_RST;
    end else begin
      head_r <= head_nxt; // RL1
      tail_r <= tail_r + pqdc_pkg::PQDC_IDX_W'(ins_valid); // RL17
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      occupancy_r <= pqdc_pkg::PQDC_CNT_RST;
      sw_cnt_r <= pqdc_pkg::PQDC_CNT_RST;
    end else begin
      occupancy_r <= cnt_nxt; // RL2
      sw_cnt_r <= sw_nxt; // RL2
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // head presented to the pipeline, taken from the next state
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      iss_valid_r <= 1'b0;
      iss_entry_r <= pqdc_pkg::PQDC_ENTRY_RST;
    end else begin
      iss_valid_r <= (cnt_nxt != pqdc_pkg::PQDC_CNT_RST);
      if (ins_valid && tail_r == head_nxt) begin
        iss_entry_r <= ins_entry;
      end else begin
        iss_entry_r <= mem_r[head_nxt];
      end
    end
  end

  pqdc_head_age u_age (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(pop || !iss_valid_r),
    .age_r(head_age_r)
  );

  ////////////////////////////////////////////////////////////////////////
  // issue slot forcing and pipeline replay
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blk_issue_r <= 1'b0;
    end else begin
      blk_issue_r <= iss_valid_r && over && hd_sw && !hd_wait && !blk_issue_r; // RL4
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      replay_r <= 1'b0;
    end else begin
      // held while software prefetches are at risk and nothing can issue
      replay_r <= iss_valid_r && hd_wait
        && (sw_cnt_r >= pqdc_pkg::PQDC_SW_MAX); // RL5
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ovf_drop_r <= 1'b0;
      stale_drop_r <= 1'b0;
    end else begin
      ovf_drop_r <= ovf; // RL1
      stale_drop_r <= hw_drop; // RL3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-hint drop filtering of lookup results
  pqdc_drop_filter u_flt (
    .res(res),
    .drop(flt_drop),
    .why(flt_why),
    .l1_fill(flt_l1)
  );

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_drop_r <= 1'b0;
      res_why_r <= pqdc_pkg::PQDC_WHY_NONE;
      l1_fill_r <= 1'b0;
      l2_fill_r <= 1'b0;
    end else begin
      res_drop_r <= res_valid && flt_drop; // RL7
      res_why_r <= res_valid ? flt_why : pqdc_pkg::PQDC_WHY_NONE;
      l1_fill_r <= res_valid && flt_l1; // RL15
      l2_fill_r <= res_valid && !flt_drop && !res.l2_hit; // RL15
    end
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  property p_ovf;
    ins_valid && full && !pop_norm |=> ovf_drop_r && full;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not handled"); // RL1

  property p_cnt;
    ins_valid && !pop |=> occupancy_r == $past(occupancy_r) + 4'h1;
  endproperty
  a_cnt: assert property (p_cnt) else $error("insert not counted"); // RL17

  property p_sw_le;
    sw_cnt_r <= occupancy_r && occupancy_r <= pqdc_pkg::PQDC_FULL;
  endproperty
  a_sw_le: assert property (p_sw_le) else $error("counts inconsistent"); // RL2

  property p_stale;
    iss_valid_r && over && !hd_sw |=> stale_drop_r;
  endproperty
  a_stale: assert property (p_stale) else $error("stale head kept"); // RL3

  property p_blk;
    blk_issue_r |-> $past(iss_valid_r) && $past(hd_sw) && !$past(hd_wait) ##1 !blk_issue_r;
  endproperty
  a_blk: assert property (p_blk) else $error("bad issue block"); // RL4

  property p_rply;
    iss_valid_r && hd_wait && sw_cnt_r >= pqdc_pkg::PQDC_SW_MAX |=> replay_r;
  endproperty
  a_rply: assert property (p_rply) else $error("replay missing"); // RL5

  property p_any;
    ins_valid && ins_entry.hint == pqdc_pkg::PQDC_HINT_ANY && !pop
      |=> sw_cnt_r == $past(sw_cnt_r);
  endproperty
  a_any: assert property (p_any) else $error("any-hint counted as sw"); // RL6

  property p_l1hit;
    res_valid && res.l1_hit |=> res_drop_r && !l1_fill_r && !l2_fill_r;
  endproperty
  a_l1hit: assert property (p_l1hit) else $error("l1 hit kept"); // RL7

  property p_l2sec;
    res_valid && res.l2_sec |=> res_drop_r;
  endproperty
  a_l2sec: assert property (p_l2sec) else $error("secondary kept"); // RL14

  property p_cancel;
    res_valid && res.fill_cancel |=> !l1_fill_r;
  endproperty
  a_cancel: assert property (p_cancel) else $error("cancelled fill sent"); // RL15

  property p_l2miss;
    res_valid && res.hint != pqdc_pkg::PQDC_HINT_NORMAL && res.l2_miss |=> res_drop_r;
  endproperty
  a_l2miss: assert property (p_l2miss) else $error("hinted miss kept"); // RL13

  property p_fbusy;
    res_valid && res.hint != pqdc_pkg::PQDC_HINT_NORMAL && !res.no_alloc
      && (res.fab_full || res.fab_same) |=> res_drop_r && !l1_fill_r;
  endproperty
  a_fbusy: assert property (p_fbusy) else $error("fill-only prefetch kept"); // RL8

  property p_tlb1;
    res_valid && res.hint == pqdc_pkg::PQDC_HINT_ANY && res.tlb1_miss |=> res_drop_r;
  endproperty
  a_tlb1: assert property (p_tlb1) else $error("tlb1 miss kept"); // RL9

  property p_xlat;
    res_valid && res.hint != pqdc_pkg::PQDC_HINT_NORMAL && res.xlat_miss |=> res_drop_r;
  endproperty
  a_xlat: assert property (p_xlat) else $error("translation miss kept"); // RL10

  property p_fault;
    res_valid && res.virt && !res.faulting && res.addr_fault
      |=> res_drop_r && res_why_r == pqdc_pkg::PQDC_WHY_ADDR_FAULT;
  endproperty
  a_fault: assert property (p_fault) else $error("faulting address kept"); // RL11

  property p_l2hit;
    res_valid && (!res.virt || res.no_alloc) && res.l2_hit |=> res_drop_r;
  endproperty
  a_l2hit: assert property (p_l2hit) else $error("mid-level hit kept"); // RL12

  property p_swkeep;
    iss_valid_r && hd_sw && !iss_take |=> !stale_drop_r;
  endproperty
  a_swkeep: assert property (p_swkeep) else $error("software head dropped"); // RL16

  property p_ageclr;
    pop |=> head_age_r == pqdc_pkg::PQDC_AGE_RST;
  endproperty
  a_ageclr: assert property (p_ageclr) else $error("head age not restarted"); // RL2

  property p_rplyoff;
    !hd_wait |=> !replay_r;
  endproperty
  a_rplyoff: assert property (p_rplyoff) else $error("replay without wait"); // RL5

  c_drop: cover property (res_valid ##1 res_drop_r);
  c_ovf: cover property (ovf_drop_r);
  c_blk: cover property (blk_issue_r);
  c_rply: cover property (replay_r [*3]);
  c_stale: cover property (stale_drop_r);
endmodule

// file: verif/pqdc_pipe_model.sv
// pqdc_pipe_model: memory ports and cache lookups on the far side of the queue
// assumes the bench commands taking, head waiting and lookup results
`timescale 1ns/1ps
module pqdc_pipe_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // commands
  input wire logic take_en,
  input wire logic take_slow,
  input wire logic wait_en,
  input wire logic res_req,
  input wire pqdc_pkg::pqdc_res_t res_in,
  // pipeline side
  output logic iss_take,
  output logic hd_wait,
  output logic res_valid,
  output pqdc_pkg::pqdc_res_t res
);
  ////////////////////////////////////////////////////////////////////////////
  // slow mode takes the head only every other cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      iss_take <= 1'b0;
      hd_wait <= 1'b0;
    end else begin
      iss_take <= take_en & ~(take_slow & iss_take);
      hd_wait <= wait_en;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // result lines toggle when no lookup is reported
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_valid <= 1'b0;
      res <= '0;
    end else begin
      res_valid <= res_req;
      res <= res_req ? res_in : ~res;
    end
  end
endmodule

// file: verif/test_prefetch_queue_drop_control.sv
// test_prefetch_queue_drop_control: self-checking bench of pqdc_top
// assumes the pipe model stands on the issue and lookup side
`timescale 1ns/1ps
module test_prefetch_queue_drop_control;
  localparam pqdc_pkg::pqdc_hint_t HN = pqdc_pkg::PQDC_HINT_NORMAL;
  localparam pqdc_pkg::pqdc_hint_t HT = pqdc_pkg::PQDC_HINT_TLB_L2;
  localparam pqdc_pkg::pqdc_hint_t HA = pqdc_pkg::PQDC_HINT_ANY;
  localparam logic [12:0] NA = 13'h1000, V = 13'h0800, FLT = 13'h0400, AF = 13'h0200;
  localparam logic [12:0] L1H = 13'h0100, FF = 13'h0080, FS = 13'h0040, T1 = 13'h0020;
  localparam logic [12:0] XM = 13'h0010, L2H = 13'h0008, L2M = 13'h0004, L2S = 13'h0002;
  localparam logic [12:0] FC = 13'h0001;
  logic ref_clk, sys_rst, ins_valid, iss_valid_r, iss_take, hd_wait, blk_issue_r, replay_r;
  logic ovf_drop_r, stale_drop_r, res_valid, res_drop_r, l1_fill_r, l2_fill_r;
  logic take_en, take_slow, wait_en, res_req;
  pqdc_pkg::pqdc_entry_t ins_entry, iss_entry_r;
  pqdc_pkg::pqdc_res_t res, res_in;
  pqdc_pkg::pqdc_why_t res_why_r;
  logic [3:0] occupancy_r, sw_cnt_r;
  logic [5:0] head_age_r;
  logic [7:0] taken[$];
  int bad_count, check_count, cyc, i, n;

  pqdc_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ins_valid(ins_valid),
    .ins_entry(ins_entry), .iss_valid_r(iss_valid_r), .iss_entry_r(iss_entry_r),
    .iss_take(iss_take), .hd_wait(hd_wait), .blk_issue_r(blk_issue_r), .replay_r(replay_r),
    .ovf_drop_r(ovf_drop_r), .stale_drop_r(stale_drop_r), .occupancy_r(occupancy_r),
    .sw_cnt_r(sw_cnt_r), .head_age_r(head_age_r), .res_valid(res_valid), .res(res),
    .res_drop_r(res_drop_r), .res_why_r(res_why_r), .l1_fill_r(l1_fill_r),
    .l2_fill_r(l2_fill_r));
  pqdc_pipe_model u_pipe (.ref_clk(ref_clk), .sys_rst(sys_rst), .take_en(take_en),
    .take_slow(take_slow), .wait_en(wait_en), .res_req(res_req), .res_in(res_in),
    .iss_take(iss_take), .hd_wait(hd_wait), .res_valid(res_valid), .res(res));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) begin
    if (iss_valid_r === 1'b1 && iss_take === 1'b1) taken.push_back(iss_entry_r.line[7:0]);
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task step;
    @(posedge ref_clk);
    #1;
  endtask
  function pqdc_pkg::pqdc_entry_t ent(input logic [7:0] ln, input logic sw,
                                      input pqdc_pkg::pqdc_hint_t h);
    ent = pqdc_pkg::PQDC_ENTRY_RST;
    ent.line[7:0] = ln;
    ent.sw = sw;
    ent.hint = h;
  endfunction
  function pqdc_pkg::pqdc_res_t mk(input pqdc_pkg::pqdc_hint_t h, input logic [12:0] f);
    mk = {h, f};
  endfunction
  task put(input pqdc_pkg::pqdc_entry_t e);
    @(posedge ref_clk);
    ins_valid <= 1'b1;
    ins_entry <= e;
  endtask
  task idle;
    @(posedge ref_clk);
    ins_valid <= 1'b0;
    ins_entry <= ~ins_entry;
    #1;
  endtask
  task drain;
    @(posedge ref_clk);
    take_en <= 1'b1;
    take_slow <= 1'b0;
    for (n = 0; n < 40 && occupancy_r !== 4'h0; n++) step();
    @(posedge ref_clk);
    take_en <= 1'b0;
    step();
    check(occupancy_r, 4'h0);
    check(iss_valid_r, 1'b0);
  endtask
  task chk_res(input pqdc_pkg::pqdc_res_t r, input logic [6:0] exp);
    @(posedge ref_clk);
    res_req <= 1'b1;
    res_in <= r;
    @(posedge ref_clk);
    res_req <= 1'b0;
    step();
    check({res_drop_r, res_why_r, l1_fill_r, l2_fill_r}, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // overflow drops the oldest, then a slow drain with a retry at the tail
  task t_overflow;
    for (i = 1; i <= 9; i++) put(ent(8'(i), 1'b0, HN));
    idle();
    check(ovf_drop_r, 1'b1);
    check(occupancy_r, 4'h8);
    check(iss_entry_r.line[7:0], 8'h02);
    step();
    check(ovf_drop_r, 1'b0);
    taken.delete();
    @(posedge ref_clk);
    take_en <= 1'b1;
    take_slow <= 1'b1;
    for (n = 0; n < 10 && taken.size() < 2; n++) step();
    put(ent(8'h0A, 1'b0, HN));
    idle();
    for (n = 0; n < 40 && occupancy_r !== 4'h0; n++) step();
    @(posedge ref_clk);
    take_en <= 1'b0;
    check(taken.size(), 9);
    for (i = 0; i < taken.size(); i++) check(taken[i], i + 2);
  endtask
  // old hardware head dropped, old software head forces an issue slot
  task t_age;
    put(ent(8'h30, 1'b0, HN));
    put(ent(8'h31, 1'b1, HN));
    idle();
    for (n = 0; n < 60 && stale_drop_r !== 1'b1; n++) step();
    check(stale_drop_r, 1'b1);
    check(n, pqdc_pkg::PQDC_AGE_MAX);
    step();
    check(iss_entry_r.line[7:0], 8'h31);
    check(sw_cnt_r, 4'h1);
    for (n = 0; n < 60 && blk_issue_r !== 1'b1; n++) step();
    check(blk_issue_r, 1'b1);
    check(head_age_r, pqdc_pkg::PQDC_AGE_MAX);
    step();
    check(blk_issue_r, 1'b0);
    drain();
  endtask
  // many software prefetches: any-miss head counts as hardware, then block and replay
  task t_sw_full;
    put(ent(8'h20, 1'b1, HA));
    for (i = 1; i <= 6; i++) put(ent(8'(8'h20 + i), 1'b1, HN));
    idle();
    check(sw_cnt_r, 4'h6);
    for (n = 0; n < 4 && stale_drop_r !== 1'b1; n++) step();
    check(stale_drop_r, 1'b1);
    for (n = 0; n < 4 && blk_issue_r !== 1'b1; n++) step();
    check(blk_issue_r, 1'b1);
    check(iss_entry_r.line[7:0], 8'h21);
    @(posedge ref_clk);
    wait_en <= 1'b1;
    repeat (4) step();
    check(replay_r, 1'b1);
    check(blk_issue_r, 1'b0);
    check(occupancy_r, 4'h6);
    @(posedge ref_clk);
    wait_en <= 1'b0;
    drain();
    check(replay_r, 1'b0);
  endtask
  task t_results;
    chk_res(mk(HN, V | L1H), {1'b1, pqdc_pkg::PQDC_WHY_L1_HIT, 2'b00});
    chk_res(mk(HT, V | FF), {1'b1, pqdc_pkg::PQDC_WHY_FILL_BUSY, 2'b00});
    chk_res(mk(HA, V | FS), {1'b1, pqdc_pkg::PQDC_WHY_FILL_BUSY, 2'b00});
    chk_res(mk(HT, V | NA | FF), {1'b0, pqdc_pkg::PQDC_WHY_NONE, 2'b01});
    chk_res(mk(HA, V | T1), {1'b1, pqdc_pkg::PQDC_WHY_TLB1_MISS, 2'b00});
    chk_res(mk(HT, V | T1), {1'b0, pqdc_pkg::PQDC_WHY_NONE, 2'b01});
    chk_res(mk(HT, V | XM), {1'b1, pqdc_pkg::PQDC_WHY_XLAT_MISS, 2'b00});
    chk_res(mk(HN, V | XM), {1'b0, pqdc_pkg::PQDC_WHY_NONE, 2'b11});
    chk_res(mk(HN, V | AF | L1H), {1'b1, pqdc_pkg::PQDC_WHY_ADDR_FAULT, 2'b00});
    chk_res(mk(HN, V | FLT | AF), {1'b0, pqdc_pkg::PQDC_WHY_NONE, 2'b11});
    chk_res(mk(HN, V | NA | L2H), {1'b1, pqdc_pkg::PQDC_WHY_L2_HIT, 2'b00});
    chk_res(mk(HN, L2H), {1'b1, pqdc_pkg::PQDC_WHY_L2_HIT, 2'b00});
    chk_res(mk(HN, V | L2H), {1'b0, pqdc_pkg::PQDC_WHY_NONE, 2'b10});
    chk_res(mk(HT, V | L2M), {1'b1, pqdc_pkg::PQDC_WHY_L2_MISS, 2'b00});
    chk_res(mk(HN, V | L2M), {1'b0, pqdc_pkg::PQDC_WHY_NONE, 2'b11});
    chk_res(mk(HN, V | L2S), {1'b1, pqdc_pkg::PQDC_WHY_L2_SEC, 2'b00});
    chk_res(mk(HN, V | FC), {1'b0, pqdc_pkg::PQDC_WHY_NONE, 2'b01});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    ins_valid = 1'b0;
    ins_entry = '0;
    {take_en, take_slow, wait_en, res_req} = 4'h0;
    res_in = '0;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    step();
    check({iss_valid_r, blk_issue_r, replay_r, ovf_drop_r, stale_drop_r, occupancy_r,
           sw_cnt_r, head_age_r, res_drop_r, res_why_r, l1_fill_r, l2_fill_r}, 0);
    t_overflow();
    t_age();
    t_sw_full();
    t_results();
    finish_test();
  end
endmodule
